// ===== rtl/sps_defines.vh
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH
// handshake status bit positions
`define SPS_HS_CTS_BIT 4
`define SPS_HS_DSR_BIT 5
// strap bit positions in global option registers
`define SPS_CFG2_PORTSEL_BIT 6
`define SPS_CFG_DEFCLR_BIT 0
`define SPS_CFG_KBC_BIT 2
// configuration port addresses
`define SPS_CFG_PORT_ALT 8'h4e
`define SPS_CFG_PORT_DEF 8'h2e
// serial timing and transmit fifo size
`define SPS_BIT_CYCLES 16'h01b2
`define SPS_FIFO_DEPTH 32
`define SPS_FIFO_AW 5
`endif

// ===== rtl/sps_fifo.v
`timescale 1ns/1ns
`include "sps_defines.vh"
module sps_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  reg [AW:0] cnt_next;
  reg full_reg;
  wire do_wr;
  wire do_rd;
  // ready comes from a flop so the port sees no logic path
  assign in_ready = !full_reg;
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always @* begin
    cnt_next = cnt_reg;
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always @(posedge clock) begin
    if (do_wr) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      full_reg <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == DEPTH[AW:0]);
    end
  end
endmodule

// ===== rtl/sps_serial_pins.v
`timescale 1ns/1ns
`include "sps_defines.vh"
module sps_serial_pins (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // controller side, per channel (index 0 = a, 1 = b)
  input wire [1:0] term_ready_ctl,
  input wire [7:0] tx_data_a,
  input wire tx_valid_a,
  output wire tx_ready_a,
  input wire [7:0] tx_data_b,
  input wire tx_valid_b,
  output wire tx_ready_b,
  output reg [7:0] rx_data_a,
  output reg rx_strobe_a,
  output reg [7:0] rx_data_b,
  output reg rx_strobe_b,
  output reg [7:0] hs_status_a,
  output reg [7:0] hs_status_b,
  // strap results
  output reg [7:0] global_option_cfg_reg,
  output reg [7:0] global_option_cfg_reg2,
  output reg [7:0] cfg_port_addr,
  output reg defaults_clear,
  output reg kbd_ctrl_enable_bit,
  output reg straps_valid,
  // modem pins
  input wire clear_to_send_chan_a,
  input wire clear_to_send_chan_b,
  input wire set_ready_chan_a,
  input wire set_ready_chan_b,
  input wire serial_in_chan_a,
  input wire serial_in_chan_b,
  // rts a / port select strap pin
  input wire req_to_send_chan_a_in,
  output reg req_to_send_chan_a_out,
  output reg req_to_send_chan_a_oe,
  output reg req_to_send_chan_b,
  // dtr a / defaults clear strap pin
  input wire term_ready_chan_a_in,
  output reg term_ready_chan_a_out,
  output reg term_ready_chan_a_oe,
  output reg term_ready_chan_b,
  // serial out a / keyboard enable strap pin
  input wire serial_out_chan_a_in,
  output reg serial_out_chan_a_out,
  output reg serial_out_chan_a_oe,
  output reg serial_out_chan_b,
  // internal pull-down enable on the three strap pins
  output reg strap_pulldown_en
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_STOP = 2'd2;
  localparam ST_HOLD = 2'd3;

  // three-stage synchronisers; bits: 0 cts a,1 cts b,2 dsr a,3 dsr b,
  // 4 sin a,5 sin b,6..8 straps
  reg [8:0] s1_reg;
  reg [8:0] s2_reg;
  reg [8:0] s3_reg;
  reg [8:0] clean_reg;
  reg in_reset_reg;

  // a change is taken only once stages two and three agree
  function [8:0] settle;
    input [8:0] prev;
    input [8:0] a;
    input [8:0] b;
    begin
      settle = (a & b) | (prev & (a | b));
    end
  endfunction

  // straps use the filtered next value, settled while reset was held
  wire [8:0] clean_next;
  assign clean_next = settle(clean_reg, s2_reg, s3_reg);

  always @(posedge clock) begin
    s1_reg <= {serial_out_chan_a_in, term_ready_chan_a_in,
               req_to_send_chan_a_in, serial_in_chan_b, serial_in_chan_a,
               set_ready_chan_b, set_ready_chan_a,
               clear_to_send_chan_b, clear_to_send_chan_a};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (!rst_n) begin
      clean_reg <= 9'h03f;
    end else begin
      clean_reg <= clean_next;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      in_reset_reg <= 1'b1;
      strap_pulldown_en <= 1'b1;
      straps_valid <= 1'b0;
      global_option_cfg_reg <= 8'h00;
      global_option_cfg_reg2 <= 8'h00;
      cfg_port_addr <= `SPS_CFG_PORT_DEF;
      defaults_clear <= 1'b0;
      kbd_ctrl_enable_bit <= 1'b0;
    end else if (in_reset_reg) begin
      in_reset_reg <= 1'b0;
      strap_pulldown_en <= 1'b0;
      straps_valid <= 1'b1;
      global_option_cfg_reg2[`SPS_CFG2_PORTSEL_BIT] <= clean_next[6];
      global_option_cfg_reg[`SPS_CFG_DEFCLR_BIT] <= clean_next[7];
      global_option_cfg_reg[`SPS_CFG_KBC_BIT] <= clean_next[8];
      kbd_ctrl_enable_bit <= clean_next[8];
      cfg_port_addr <= clean_next[6] ? `SPS_CFG_PORT_ALT
                                     : `SPS_CFG_PORT_DEF;
      defaults_clear <= clean_next[7];
    end
  end

  // transmit fifos feed the shifters; ready stalls the source when full
  wire fa_valid;
  wire fb_valid;
  wire [7:0] fa_data;
  wire [7:0] fb_data;
  reg take_a;
  reg take_b;
  sps_fifo #(.WIDTH(8), .DEPTH(`SPS_FIFO_DEPTH), .AW(`SPS_FIFO_AW)) u_fa (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(tx_valid_a),
    .in_ready(tx_ready_a),
    .in_data(tx_data_a),
    .out_valid(fa_valid),
    .out_ready(take_a),
    .out_data(fa_data)
  );
  sps_fifo #(.WIDTH(8), .DEPTH(`SPS_FIFO_DEPTH), .AW(`SPS_FIFO_AW)) u_fb (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(tx_valid_b),
    .in_ready(tx_ready_b),
    .in_data(tx_data_b),
    .out_valid(fb_valid),
    .out_ready(take_b),
    .out_data(fb_data)
  );

  // per-channel 8n1 shifters, index 0 = a, 1 = b
  reg [1:0] tst_reg [0:1];
  reg [15:0] tcnt_reg [0:1];
  reg [2:0] tbit_reg [0:1];
  reg [7:0] tsh_reg [0:1];
  reg [1:0] txd_reg;
  reg [1:0] rst_st_reg [0:1];
  reg [15:0] rcnt_reg [0:1];
  reg [2:0] rbit_reg [0:1];
  reg [7:0] rsh_reg [0:1];
  reg [1:0] rdone_reg;
  wire [1:0] fvalid;
  wire [7:0] fdata [0:1];
  wire [1:0] sin_clean;
  assign fvalid = {fb_valid, fa_valid};
  assign fdata[0] = fa_data;
  assign fdata[1] = fb_data;
  assign sin_clean = clean_reg[5:4];

  always @* begin
    take_a = (tst_reg[0] == ST_IDLE) && fa_valid && !in_reset_reg;
    take_b = (tst_reg[1] == ST_IDLE) && fb_valid && !in_reset_reg;
  end

  integer i;
  always @(posedge clock) begin
    for (i = 0; i < 2; i = i + 1) begin
      if (!rst_n) begin
        tst_reg[i] <= ST_IDLE;
        tcnt_reg[i] <= 16'h0000;
        tbit_reg[i] <= 3'h0;
        tsh_reg[i] <= 8'h00;
        txd_reg[i] <= 1'b1;
        rst_st_reg[i] <= ST_IDLE;
        rcnt_reg[i] <= 16'h0000;
        rbit_reg[i] <= 3'h0;
        rsh_reg[i] <= 8'h00;
        rdone_reg[i] <= 1'b0;
      end else begin
        rdone_reg[i] <= 1'b0;
        case (tst_reg[i])
          ST_IDLE: begin
            txd_reg[i] <= 1'b1;
            if (fvalid[i] && !in_reset_reg) begin
              tsh_reg[i] <= fdata[i];
              txd_reg[i] <= 1'b0;
              tcnt_reg[i] <= `SPS_BIT_CYCLES;
              tbit_reg[i] <= 3'h0;
              tst_reg[i] <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tcnt_reg[i] == 16'h0001) begin
              tcnt_reg[i] <= `SPS_BIT_CYCLES;
              txd_reg[i] <= tsh_reg[i][0];
              tsh_reg[i] <= {1'b1, tsh_reg[i][7:1]};
              tbit_reg[i] <= tbit_reg[i] + 3'h1;
              if (tbit_reg[i] == 3'h7) begin
                tst_reg[i] <= ST_STOP;
              end
            end else begin
              tcnt_reg[i] <= tcnt_reg[i] - 16'h0001;
            end
          end
          ST_STOP: begin
            if (tcnt_reg[i] == 16'h0001) begin
              txd_reg[i] <= 1'b1;
              tcnt_reg[i] <= `SPS_BIT_CYCLES;
              tst_reg[i] <= ST_HOLD;
            end else begin
              tcnt_reg[i] <= tcnt_reg[i] - 16'h0001;
            end
          end
          // a full stop bit, else a queued byte would start at once
          ST_HOLD: begin
            if (tcnt_reg[i] == 16'h0001) begin
              tst_reg[i] <= ST_IDLE;
            end else begin
              tcnt_reg[i] <= tcnt_reg[i] - 16'h0001;
            end
          end
          default: tst_reg[i] <= ST_IDLE;
        endcase
        case (rst_st_reg[i])
          ST_IDLE: begin
            if (!sin_clean[i]) begin
              rcnt_reg[i] <= `SPS_BIT_CYCLES + (`SPS_BIT_CYCLES >> 1);
              rbit_reg[i] <= 3'h0;
              rst_st_reg[i] <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (rcnt_reg[i] == 16'h0001) begin
              rcnt_reg[i] <= `SPS_BIT_CYCLES;
              rsh_reg[i] <= {sin_clean[i], rsh_reg[i][7:1]};
              rbit_reg[i] <= rbit_reg[i] + 3'h1;
              if (rbit_reg[i] == 3'h7) begin
                rst_st_reg[i] <= ST_STOP;
              end
            end else begin
              rcnt_reg[i] <= rcnt_reg[i] - 16'h0001;
            end
          end
          ST_STOP: begin
            if (rcnt_reg[i] == 16'h0001) begin
              // framing error drops the byte
              rdone_reg[i] <= sin_clean[i];
              rst_st_reg[i] <= ST_IDLE;
            end else begin
              rcnt_reg[i] <= rcnt_reg[i] - 16'h0001;
            end
          end
          default: rst_st_reg[i] <= ST_IDLE;
        endcase
      end
    end
  end

  // pin and status outputs, all registered
  always @(posedge clock) begin
    if (!rst_n) begin
      rx_data_a <= 8'h00;
      rx_data_b <= 8'h00;
      rx_strobe_a <= 1'b0;
      rx_strobe_b <= 1'b0;
      hs_status_a <= 8'h00;
      hs_status_b <= 8'h00;
      req_to_send_chan_a_out <= 1'b1;
      req_to_send_chan_a_oe <= 1'b0;
      req_to_send_chan_b <= 1'b1;
      term_ready_chan_a_out <= 1'b1;
      term_ready_chan_a_oe <= 1'b0;
      term_ready_chan_b <= 1'b1;
      serial_out_chan_a_out <= 1'b1;
      serial_out_chan_a_oe <= 1'b0;
      serial_out_chan_b <= 1'b1;
    end else begin
      rx_strobe_a <= rdone_reg[0];
      rx_strobe_b <= rdone_reg[1];
      if (rdone_reg[0]) begin
        rx_data_a <= rsh_reg[0];
      end
      if (rdone_reg[1]) begin
        rx_data_b <= rsh_reg[1];
      end
      // cts on bit 4, dsr beside it, active state as one
      hs_status_a <= 8'h00;
      hs_status_b <= 8'h00;
      hs_status_a[`SPS_HS_CTS_BIT] <= !clean_reg[0];
      hs_status_b[`SPS_HS_CTS_BIT] <= !clean_reg[1];
      hs_status_a[`SPS_HS_DSR_BIT] <= !clean_reg[2];
      hs_status_b[`SPS_HS_DSR_BIT] <= !clean_reg[3];
      // the three channel a strap pins drive only once straps are latched; the b pins drive from reset
      req_to_send_chan_a_oe <= !in_reset_reg;
      term_ready_chan_a_oe <= !in_reset_reg;
      serial_out_chan_a_oe <= !in_reset_reg;
      req_to_send_chan_a_out <= !(fa_valid || tst_reg[0] != ST_IDLE);
      req_to_send_chan_b <= !(fb_valid || tst_reg[1] != ST_IDLE);
      term_ready_chan_a_out <= !term_ready_ctl[0];
      term_ready_chan_b <= !term_ready_ctl[1];
      serial_out_chan_a_out <= txd_reg[0];
      serial_out_chan_b <= txd_reg[1];
    end
  end
endmodule

// ===== bench/sps_serial_pins_asserts.sv
`timescale 1ns/1ns
module sps_pin_chk (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // controller side
  input wire [1:0] term_ready_ctl,
  input wire tx_valid_b,
  input wire tx_ready_b,
  input wire rx_strobe_a,
  input wire [7:0] hs_status_a,
  // strap results
  input wire [7:0] global_option_cfg_reg,
  input wire [7:0] global_option_cfg_reg2,
  input wire [7:0] cfg_port_addr,
  input wire defaults_clear,
  input wire kbd_ctrl_enable_bit,
  input wire straps_valid,
  // pins
  input wire clear_to_send_chan_a,
  input wire req_to_send_chan_a_oe,
  input wire req_to_send_chan_b,
  input wire term_ready_chan_b,
  input wire serial_out_chan_b,
  input wire strap_pulldown_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // the pin is asynchronous, so only a settled level is judged
  cts_bit_a: assert property ($stable(clear_to_send_chan_a) [*6]
    |-> hs_status_a[4] == !clear_to_send_chan_a) else $error("cts bit");
  rts_push_a: assert property (tx_valid_b && tx_ready_b
    |-> ##[1:3] !req_to_send_chan_b) else $error("rts not low");
  dtr_level_a: assert property ($stable(term_ready_ctl[1]) [*3]
    |-> term_ready_chan_b == !term_ready_ctl[1]) else $error("dtr level");
  tx_idle_a: assert property (req_to_send_chan_b [*2]
    |-> serial_out_chan_b) else $error("tx line not idle");
  rx_pulse_a: assert property (rx_strobe_a |=> !rx_strobe_a)
    else $error("rx strobe too long");
  pull_rel_a: assert property ($rose(straps_valid)
    |-> !strap_pulldown_en ##1 req_to_send_chan_a_oe)
    else $error("pull-down release");
  port_addr_a: assert property (straps_valid |-> cfg_port_addr ==
    (global_option_cfg_reg2[6] ? 8'h4e : 8'h2e)) else $error("port address");
  strap_hold_a: assert property (straps_valid [*2] |->
    $stable({global_option_cfg_reg, global_option_cfg_reg2}))
    else $error("strap changed");
  strap_flag_a: assert property (straps_valid |->
    kbd_ctrl_enable_bit == global_option_cfg_reg[2] &&
    defaults_clear == global_option_cfg_reg[0]) else $error("strap flags");
endmodule
bind sps_serial_pins sps_pin_chk chk (.*);

// ===== bench/sps_modem_model.sv
`timescale 1ns/1ns
`include "sps_defines.vh"
module sps_modem_model (
  // device pin drive
  input wire clock,
  input wire strap_pulldown_en,
  input wire req_to_send_chan_a_out,
  input wire req_to_send_chan_a_oe,
  input wire term_ready_chan_a_out,
  input wire term_ready_chan_a_oe,
  input wire serial_out_chan_a_out,
  input wire serial_out_chan_a_oe,
  // resolved pin levels
  output wire req_to_send_chan_a_in,
  output wire term_ready_chan_a_in,
  output wire serial_out_chan_a_in,
  // modem driven lines
  output wire serial_in_chan_b,
  output reg serial_in_chan_a,
  output reg clear_to_send_chan_a,
  output reg clear_to_send_chan_b,
  output reg set_ready_chan_a,
  output reg set_ready_chan_b
);
  // external pull-ups {sout, dtr, rts}; they outvote the internal pull-down
  reg [2:0] straps;
  function lvl(input oe, input o, input s, input pd);
    // a floating pin shows the inverse, never a kindly held value
    lvl = oe ? o : (s | (!pd & !o));
  endfunction
  assign req_to_send_chan_a_in = lvl(req_to_send_chan_a_oe,
    req_to_send_chan_a_out, straps[0], strap_pulldown_en);
  assign term_ready_chan_a_in = lvl(term_ready_chan_a_oe,
    term_ready_chan_a_out, straps[1], strap_pulldown_en);
  assign serial_out_chan_a_in = lvl(serial_out_chan_a_oe,
    serial_out_chan_a_out, straps[2], strap_pulldown_en);
  // null-modem wiring: channel a output returns on channel b
  assign serial_in_chan_b = serial_out_chan_a_in;
  initial begin
    straps = 3'h0;
    serial_in_chan_a = 1'b1;
    clear_to_send_chan_a = 1'b0;
    clear_to_send_chan_b = 1'b0;
    set_ready_chan_a = 1'b0;
    set_ready_chan_b = 1'b0;
  end
  task send(input [7:0] d);
    integer k;
    reg [9:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge clock);
        #2 serial_in_chan_a = f[k];
        repeat (`SPS_BIT_CYCLES - 1) @(posedge clock);
      end
    end
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
`include "sps_defines.vh"
module tb;
  reg clock;
  reg rst_n;
  reg [1:0] term_ready_ctl;
  reg [7:0] tx_data_a;
  reg [7:0] tx_data_b;
  reg tx_valid_a;
  reg tx_valid_b;
  wire [7:0] rx_data_a, rx_data_b, hs_status_a, hs_status_b;
  wire [7:0] global_option_cfg_reg, global_option_cfg_reg2, cfg_port_addr;
  wire tx_ready_a, tx_ready_b, rx_strobe_a, rx_strobe_b, defaults_clear;
  wire kbd_ctrl_enable_bit, straps_valid, strap_pulldown_en;
  wire req_to_send_chan_a_out, req_to_send_chan_a_oe, req_to_send_chan_a_in;
  wire term_ready_chan_a_out, term_ready_chan_a_oe, term_ready_chan_a_in;
  wire serial_out_chan_a_out, serial_out_chan_a_oe, serial_out_chan_a_in;
  wire req_to_send_chan_b, term_ready_chan_b, serial_out_chan_b;
  wire serial_in_chan_a, serial_in_chan_b, clear_to_send_chan_a;
  wire clear_to_send_chan_b, set_ready_chan_a, set_ready_chan_b;
  integer err_count = 0;
  integer total_checks = 0;
  integer i;
  reg ok;
  sps_serial_pins uut (.*);
  sps_modem_model m (.*);
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // valid drops for one edge between pushes, so no double drive in a step
  task push(input ch, input [7:0] d, output ok);
    begin
      @(posedge clock);
      #2 tx_valid_a = !ch;
      tx_valid_b = ch;
      tx_data_a = d;
      tx_data_b = d;
      @(negedge clock);
      ok = ch ? tx_ready_b : tx_ready_a;
      @(posedge clock);
      #2 tx_valid_a = 1'b0;
      tx_valid_b = 1'b0;
    end
  endtask
  task wait_rx(input ch, input [7:0] e);
    integer k;
    reg got;
    begin
      got = 1'b0;
      for (k = 0; k < 6000 && got !== 1'b1; k = k + 1) begin
        @(negedge clock);
        got = ch ? rx_strobe_b : rx_strobe_a;
      end
      chk("rx_strobe", 8'h01, {7'h0, got});
      chk("rx", e, ch ? rx_data_b : rx_data_a);
    end
  endtask
  task do_reset(input [2:0] s);
    begin
      @(posedge clock);
      #2 rst_n = 1'b0;
      m.straps = s;
      repeat (4) @(posedge clock);
      #2 rst_n = 1'b1;
      @(posedge clock);
      #2 chk("straps", {3'h0, s[2], s[1], s[0], s[2], s[1]},
        {3'h0, kbd_ctrl_enable_bit, defaults_clear, global_option_cfg_reg2[6],
        global_option_cfg_reg[2], global_option_cfg_reg[0]});
      chk("addr", s[0] ? `SPS_CFG_PORT_ALT : `SPS_CFG_PORT_DEF,
        cfg_port_addr);
      m.straps = ~s;
      repeat (3) @(posedge clock);
      chk("hold", {7'h0, s[0]}, {7'h0, global_option_cfg_reg2[6]});
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_count = err_count + 1;
    $display("watchdog expired");
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    term_ready_ctl = 2'h0;
    tx_valid_a = 1'b0;
    tx_valid_b = 1'b0;
    tx_data_a = 8'h00;
    tx_data_b = 8'h00;
    repeat (4) @(posedge clock);
    #2 rst_n = 1'b1;
    // serial out a loops to channel b; a low strap there looks like a start
    do_reset(3'h2);
    do_reset(3'h5);
    $display("test straps done");
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clock);
      #2 m.clear_to_send_chan_a = i[0];
      m.set_ready_chan_a = i[1];
      m.clear_to_send_chan_b = !i[0];
      m.set_ready_chan_b = !i[1];
      term_ready_ctl = i[1:0];
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk("hs_a", {2'h0, !i[1], !i[0], 4'h0}, hs_status_a);
      chk("hs_b", {2'h0, i[1], i[0], 4'h0}, hs_status_b);
      chk("dtr", {6'h0, !i[1], !i[0]},
        {6'h0, term_ready_chan_b, term_ready_chan_a_in});
    end
    $display("test handshake done");
    push(1'b0, 8'ha5, ok);
    push(1'b0, 8'h3c, ok);
    chk("rts", 8'h00, {7'h0, req_to_send_chan_a_in});
    wait_rx(1'b1, 8'ha5);
    wait_rx(1'b1, 8'h3c);
    repeat (500) @(posedge clock);
    #2 chk("rts_idle", 8'h01, {7'h0, req_to_send_chan_a_in});
    fork
      m.send(8'h5a);
      wait_rx(1'b0, 8'h5a);
    join
    $display("test serial done");
    // one byte goes straight to the shifter, the rest wait in the buffer
    i = 0;
    ok = 1'b1;
    while (ok === 1'b1 && i < 40) begin
      push(1'b1, i[7:0], ok);
      if (ok === 1'b1)
        i = i + 1;
    end
    chk("fill", 8'(`SPS_FIFO_DEPTH + 1), i[7:0]);
    $display("test fill done");
    end_of_test;
  end
endmodule
